// File: core/sec_ctrl.sv
// serial eeprom controller: wishbone registers, address auto-load, host commands
//
// The implementer's own choices: the address map and the Wishbone register port.
`timescale 1ns/10ps
module sec_ctrl #(
  parameter int TIMEOUT_CYC = sec_pkg::TIMEOUT_CYC
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        soft_reset,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [31:0] dat_i,
  input  wire logic [3:0]  sel_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // eeprom pins
  output logic             serial_clock_pin_o,
  output logic             serial_clock_pin_oe,
  input  wire logic        serial_data_pin_i,
  output logic             serial_data_pin_o,
  output logic             serial_data_pin_oe,
  output logic             eeprom_select_o,
  // internal signals for the pin monitor
  input  wire logic        mii_mon_clk,
  input  wire logic        mii_mon_data,
  // to the mac
  output logic      [47:0] station_address,
  output logic             bus_width_32
);
  typedef enum logic [5:0] {
    ST_STRAP = 6'h01, ST_LOAD = 6'h02, ST_LOADW = 6'h04,
    ST_IDLE  = 6'h08, ST_RUN  = 6'h10, ST_RUNW  = 6'h20
  } sec_state_t;

  sec_state_t          st_q;
  sec_pkg::sec_cmd_t   code_q;
  logic                busy_q;
  logic                to_flag_q;
  logic                loaded_q;
  logic [6:0]          loc_q;
  logic [7:0]          data_q;
  logic [47:0]         mac_q;
  logic [3:0]          pincfg_q;
  logic                width_q;
  logic [1:0]          strap_cnt_q;
  logic [2:0]          idx_q;
  logic                ack_q;
  logic [31:0]         rdat_q;
  logic                wr_fire;
  logic [31:0]         cmd_rd;
  logic                din_s;
  // link request
  logic                lk_start_q;
  logic [4:0]          lk_bits_q;
  logic [4:0]          lk_drv_q;
  logic [17:0]         lk_word_q;
  logic                lk_poll_q;
  logic                lk_done;
  logic                lk_to;
  logic [7:0]          lk_rx;
  logic                lk_sclk;
  logic                lk_dout;
  logic                lk_doe;
  logic                lk_cs;

  // byte-lane merge of a bus write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  // build a frame, start bit first, left aligned in 18 bits
  function automatic logic [17:0] frame(input logic [1:0] op, input logic [6:0] loc,
                                        input logic [7:0] dat);
    return {1'b1, op, loc, dat};
  endfunction : frame

  // the data pin is an outside input, synchronised before use
  sec_sync #(
    .W (1)
  ) u_din_sync (
    .clock (clock),
    .rst   (rst),
    .d     (serial_data_pin_i),
    .q     (din_s)
  );

  sec_link #(
    .TO_CYC (TIMEOUT_CYC)
  ) u_link (
    .clock   (clock),
    .rst     (rst),
    .start   (lk_start_q),
    .bits    (lk_bits_q),
    .drv     (lk_drv_q),
    .word    (lk_word_q),
    .poll    (lk_poll_q),
    .done    (lk_done),
    .timeout (lk_to),
    .rx      (lk_rx),
    .din     (din_s),
    .sclk    (lk_sclk),
    .dout    (lk_dout),
    .doe     (lk_doe),
    .cs      (lk_cs)
  );

  // wishbone: ack one cycle after the request, writes land on the ack edge
  assign wr_fire = cyc_i && stb_i && we_i && ack_q;
  assign ack_o   = ack_q;
  assign dat_o   = rdat_q;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= cyc_i && stb_i && !ack_q;
    end
  end

  assign cmd_rd = {busy_q, 1'(code_q >> 2), 2'(code_q), 18'h00000,
                   to_flag_q, loaded_q, 1'b0, loc_q};

  // read mux, unmapped offsets read as zero
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdat_q <= 32'h00000000;
    end else if (cyc_i && stb_i && !we_i && !ack_q) begin
      case (adr_i)
        sec_pkg::OFS_CMD:    rdat_q <= cmd_rd;
        sec_pkg::OFS_DATA:   rdat_q <= {24'h000000, data_q};
        sec_pkg::OFS_ADDR_L: rdat_q <= mac_q[31:0];
        sec_pkg::OFS_ADDR_H: rdat_q <= {16'h0000, mac_q[47:32]};
        sec_pkg::OFS_HWCFG:  rdat_q <= 32'(width_q) << sec_pkg::HWCFG_WIDTH_BIT;
        sec_pkg::OFS_PINCFG: rdat_q <= {28'h0000000, pincfg_q};
        default:             rdat_q <= 32'h00000000;
      endcase
    end
  end

  // pin configuration register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pincfg_q <= sec_pkg::PINCFG_RST;
    end else if (wr_fire && adr_i == sec_pkg::OFS_PINCFG) begin
      pincfg_q <= 4'(merge({28'h0000000, pincfg_q}, dat_i, sel_i));
    end
  end

  // strap caught once the synchronised pin is valid
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      width_q     <= 1'b0;
      strap_cnt_q <= 2'h0;
    end else if (st_q == ST_STRAP) begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
      if (strap_cnt_q == 2'(sec_pkg::STRAP_WAIT_CYC - 1)) begin
        width_q <= din_s;
      end
    end
  end
  assign bus_width_32 = width_q;

  // data register: a finished read beats a host write
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      data_q <= 8'h00;
    end else if (st_q == ST_RUNW && lk_done && code_q == sec_pkg::SEC_READ) begin
      data_q <= lk_rx;
    end else if (wr_fire && adr_i == sec_pkg::OFS_DATA && sel_i[0]) begin
      data_q <= dat_i[7:0];
    end
  end

  // station address: host writes, auto-load fills bytes
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mac_q <= sec_pkg::MAC_RST;
    end else if (st_q == ST_LOADW && lk_done && idx_q != 3'h0) begin
      mac_q[8*(idx_q - 3'h1) +: 8] <= lk_rx;
    end else if (wr_fire && adr_i == sec_pkg::OFS_ADDR_L) begin
      mac_q[31:0] <= merge(mac_q[31:0], dat_i, sel_i);
    end else if (wr_fire && adr_i == sec_pkg::OFS_ADDR_H) begin
      mac_q[47:32] <= 16'(merge({16'h0000, mac_q[47:32]}, dat_i, sel_i));
    end
  end
  assign station_address = mac_q;

  // command fields are taken only while idle; a busy write is ignored
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      code_q <= sec_pkg::SEC_READ;
      loc_q  <= 7'h00;
    end else if (wr_fire && adr_i == sec_pkg::OFS_CMD && !busy_q && sel_i[3]) begin
      code_q <= sec_pkg::sec_cmd_t'(dat_i[sec_pkg::CMD_CODE_LSB +: 3]);
      if (sel_i[0]) begin
        loc_q <= dat_i[sec_pkg::CMD_LOC_LSB +: 7];
      end
    end
  end

  // timeout flag: set by the link, write one to clear; the set wins
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      to_flag_q <= 1'b0;
    end else if (lk_to) begin
      to_flag_q <= 1'b1;
    end else if (wr_fire && adr_i == sec_pkg::OFS_CMD && sel_i[1]
                 && dat_i[sec_pkg::CMD_TO_BIT]) begin
      to_flag_q <= 1'b0;
    end
  end

  // main sequencer: strap, auto-load, then host commands
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_q       <= ST_STRAP;
      busy_q     <= 1'b1;   // busy through the reset-time load
      loaded_q   <= 1'b0;
      idx_q      <= 3'h0;
      lk_start_q <= 1'b0;
      lk_bits_q  <= sec_pkg::FRAME_LONG;
      lk_drv_q   <= sec_pkg::FRAME_SHORT;
      lk_word_q  <= 18'h00000;
      lk_poll_q  <= 1'b0;
    end else begin
      lk_start_q <= 1'b0;
      if (soft_reset && (st_q == ST_IDLE)) begin
        st_q     <= ST_LOAD;
        busy_q   <= 1'b1;
        loaded_q <= 1'b0;
        idx_q    <= 3'h0;
      end else begin
        case (st_q)
          ST_STRAP: begin
            if (strap_cnt_q == 2'(sec_pkg::STRAP_WAIT_CYC - 1)) begin
              st_q <= ST_LOAD;
            end
          end
          ST_LOAD: begin
            // read location idx: signature, then address bytes
            lk_word_q  <= frame(sec_pkg::OP_READ, 7'(idx_q), 8'h00);
            lk_bits_q  <= sec_pkg::FRAME_LONG;
            lk_drv_q   <= sec_pkg::FRAME_SHORT;
            lk_poll_q  <= 1'b0;
            lk_start_q <= 1'b1;
            st_q       <= ST_LOADW;
          end
          ST_LOADW: begin
            if (lk_done) begin
              if (idx_q == 3'h0 && lk_rx != sec_pkg::SIGNATURE) begin
                busy_q <= 1'b0;
                st_q   <= ST_IDLE;
              end else if (idx_q == sec_pkg::MAC_BYTES) begin
                loaded_q <= 1'b1;
                busy_q   <= 1'b0;
                st_q     <= ST_IDLE;
              end else begin
                idx_q <= idx_q + 3'h1;
                st_q  <= ST_LOAD;
              end
            end
          end
          ST_IDLE: begin
            if (wr_fire && adr_i == sec_pkg::OFS_CMD && sel_i[3]
                && dat_i[sec_pkg::CMD_BUSY_BIT]) begin
              busy_q <= 1'b1;
              st_q   <= ST_RUN;
            end
          end
          ST_RUN: begin
            lk_start_q <= 1'b1;
            lk_bits_q  <= sec_pkg::FRAME_SHORT;
            lk_drv_q   <= sec_pkg::FRAME_SHORT;
            lk_poll_q  <= 1'b1;
            st_q       <= ST_RUNW;
            case (code_q)
              sec_pkg::SEC_READ: begin
                lk_word_q <= frame(sec_pkg::OP_READ, loc_q, 8'h00);
                lk_bits_q <= sec_pkg::FRAME_LONG;
                lk_poll_q <= 1'b0;
              end
              sec_pkg::SEC_WRITE: begin
                lk_word_q <= frame(sec_pkg::OP_WRITE, loc_q, data_q);
                lk_bits_q <= sec_pkg::FRAME_LONG;
                lk_drv_q  <= sec_pkg::FRAME_LONG;
              end
              sec_pkg::SEC_FILL: begin
                lk_word_q <= frame(sec_pkg::OP_EXT, sec_pkg::EXT_FILL, data_q);
                lk_bits_q <= sec_pkg::FRAME_LONG;
                lk_drv_q  <= sec_pkg::FRAME_LONG;
              end
              sec_pkg::SEC_ERASE: begin
                lk_word_q <= frame(sec_pkg::OP_ERASE, loc_q, 8'h00);
              end
              sec_pkg::SEC_BULK: begin
                lk_word_q <= frame(sec_pkg::OP_EXT, sec_pkg::EXT_BULK, 8'h00);
              end
              sec_pkg::SEC_LOCK: begin
                lk_word_q <= frame(sec_pkg::OP_EXT, sec_pkg::EXT_LOCK, 8'h00);
                lk_poll_q <= 1'b0;
              end
              sec_pkg::SEC_UNLOCK: begin
                lk_word_q <= frame(sec_pkg::OP_EXT, sec_pkg::EXT_UNLOCK, 8'h00);
                lk_poll_q <= 1'b0;
              end
              default: begin
                // reload: the load sequence issues its own reads
                lk_start_q <= 1'b0;
                loaded_q   <= 1'b0;
                idx_q      <= 3'h0;
                st_q       <= ST_LOAD;
              end
            endcase
          end
          ST_RUNW: begin
            if (lk_done) begin
              busy_q <= 1'b0;
              st_q   <= ST_IDLE;
            end
          end
          default: st_q <= ST_IDLE;
        endcase
      end
    end
  end

  // pin mux: disabled interface gives pins to outputs or monitors
  always_comb begin
    if (pincfg_q[sec_pkg::PIN_DIS_BIT]) begin
      serial_clock_pin_o  = pincfg_q[sec_pkg::PIN_MON_BIT] ? mii_mon_clk
                                                           : pincfg_q[sec_pkg::PIN_GPO_CLK_BIT];
      serial_data_pin_o   = pincfg_q[sec_pkg::PIN_MON_BIT] ? mii_mon_data
                                                           : pincfg_q[sec_pkg::PIN_GPO_DAT_BIT];
      serial_data_pin_oe  = 1'b1;
      eeprom_select_o     = 1'b0;
    end else begin
      serial_clock_pin_o  = lk_sclk;
      serial_data_pin_o   = lk_dout;
      serial_data_pin_oe  = lk_doe;
      eeprom_select_o     = lk_cs;
    end
    serial_clock_pin_oe = 1'b1;
  end
endmodule : sec_ctrl

// File: core/sec_link.sv
// serial frame engine: one frame out, then program poll
`timescale 1ns/10ps
module sec_link #(
  parameter int TO_CYC = sec_pkg::TIMEOUT_CYC
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // request from the controller
  input  wire logic        start,
  input  wire logic [4:0]  bits,
  input  wire logic [4:0]  drv,
  input  wire logic [17:0] word,
  input  wire logic        poll,
  // answer
  output logic             done,
  output logic             timeout,
  output logic      [7:0]  rx,
  // pins (din already synchronised)
  input  wire logic        din,
  output logic             sclk,
  output logic             dout,
  output logic             doe,
  output logic             cs
);
  typedef enum logic [4:0] {
    L_IDLE = 5'h01, L_LOW = 5'h02, L_HIGH = 5'h04, L_GAP = 5'h08, L_POLL = 5'h10
  } sec_lstate_t;

  sec_lstate_t st_q;
  logic [5:0]  div_q;
  logic        tick;
  logic [4:0]  n_q;
  logic [17:0] sh_q;
  logic [20:0] to_q;

  // half-period divider, runs only during a frame
  assign tick = (div_q == 6'(sec_pkg::SCLK_HALF_CYC - 1));
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      div_q <= 6'h00;
    end else if (st_q == L_IDLE || st_q == L_POLL || tick) begin
      div_q <= 6'h00;
    end else begin
      div_q <= div_q + 6'h01;
    end
  end

  // frame sequencer: data moves with clock low
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_q    <= L_IDLE;
      n_q     <= 5'h00;
      sh_q    <= 18'h00000;
      to_q    <= 21'h000000;
      rx      <= 8'h00;
      sclk    <= 1'b0;
      dout    <= 1'b0;
      doe     <= 1'b0;
      cs      <= 1'b0;
      done    <= 1'b0;
      timeout <= 1'b0;
    end else begin
      done    <= 1'b0;
      timeout <= 1'b0;
      case (st_q)
        L_IDLE: begin
          if (start) begin
            cs   <= 1'b1;
            sh_q <= word;
            dout <= word[17];
            doe  <= (drv != 5'h00);
            n_q  <= 5'h00;
            st_q <= L_LOW;
          end
        end
        L_LOW: begin
          if (tick) begin
            sclk <= 1'b1;
            rx   <= {rx[6:0], din};   // last eight samples form the read byte
            st_q <= L_HIGH;
          end
        end
        L_HIGH: begin
          if (tick) begin
            sclk <= 1'b0;
            n_q  <= n_q + 5'h01;
            if (n_q + 5'h01 == bits) begin
              cs   <= 1'b0;
              doe  <= 1'b0;
              st_q <= L_GAP;
            end else begin
              sh_q <= {sh_q[16:0], 1'b0};
              dout <= sh_q[16];
              doe  <= (n_q + 5'h01 < drv);
              st_q <= L_LOW;
            end
          end
        end
        L_GAP: begin
          if (tick) begin
            if (poll) begin
              cs   <= 1'b1;
              to_q <= 21'h000000;
              st_q <= L_POLL;
            end else begin
              done <= 1'b1;
              st_q <= L_IDLE;
            end
          end
        end
        L_POLL: begin
          to_q <= to_q + 21'h000001;
          if (din) begin
            cs   <= 1'b0;
            done <= 1'b1;
            st_q <= L_IDLE;
          end else if (to_q == 21'(TO_CYC - 1)) begin
            cs      <= 1'b0;   // abandon a silent part
            timeout <= 1'b1;
            done    <= 1'b1;
            st_q    <= L_IDLE;
          end
        end
        default: st_q <= L_IDLE;
      endcase
    end
  end
endmodule : sec_link

// File: core/sec_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module sec_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clock,
  input  wire logic         rst,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule : sec_sync

// File: pkg/sec_pkg.sv
// constants of the serial eeprom controller
package sec_pkg;
  // timing
  localparam int CLK_PERIOD_NS  = 25;
  localparam int SCLK_HALF_NS   = 500;
  localparam int SCLK_HALF_CYC  = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMEOUT_MS     = 30;
  localparam int TIMEOUT_CYC    = (TIMEOUT_MS * 1000000) / CLK_PERIOD_NS;
  localparam int STRAP_WAIT_CYC = 3;

  // register byte offsets
  localparam logic [7:0] OFS_CMD    = 8'h00;
  localparam logic [7:0] OFS_DATA   = 8'h04;
  localparam logic [7:0] OFS_ADDR_L = 8'h08;
  localparam logic [7:0] OFS_ADDR_H = 8'h0C;
  localparam logic [7:0] OFS_HWCFG  = 8'h10;
  localparam logic [7:0] OFS_PINCFG = 8'h14;

  // command, hardware and pin register fields
  localparam int CMD_BUSY_BIT   = 31;
  localparam int CMD_CODE_LSB   = 28;
  localparam int CMD_TO_BIT     = 9;
  localparam int CMD_LOADED_BIT = 8;
  localparam int CMD_LOC_LSB    = 0;
  localparam int HWCFG_WIDTH_BIT = 2;
  localparam int PIN_DIS_BIT    = 0;
  localparam int PIN_MON_BIT    = 1;
  localparam int PIN_GPO_CLK_BIT = 2;
  localparam int PIN_GPO_DAT_BIT = 3;

  // reset values
  localparam logic [3:0]  PINCFG_RST = 4'h0;
  localparam logic [47:0] MAC_RST    = 48'h0000_0000_0000;

  // serial frame layout
  localparam logic [7:0] SIGNATURE   = 8'hA5;
  localparam logic [4:0] FRAME_SHORT = 5'h0A;
  localparam logic [4:0] FRAME_LONG  = 5'h12;
  localparam logic [1:0] OP_EXT      = 2'h0;
  localparam logic [1:0] OP_WRITE    = 2'h1;
  localparam logic [1:0] OP_READ     = 2'h2;
  localparam logic [1:0] OP_ERASE    = 2'h3;
  localparam logic [6:0] EXT_LOCK    = 7'h00;
  localparam logic [6:0] EXT_FILL    = 7'h20;
  localparam logic [6:0] EXT_BULK    = 7'h40;
  localparam logic [6:0] EXT_UNLOCK  = 7'h60;
  localparam logic [2:0] MAC_BYTES   = 3'h6;

  // command codes
  typedef enum logic [2:0] {
    SEC_READ   = 3'h0,
    SEC_LOCK   = 3'h1,
    SEC_UNLOCK = 3'h2,
    SEC_WRITE  = 3'h3,
    SEC_FILL   = 3'h4,
    SEC_ERASE  = 3'h5,
    SEC_BULK   = 3'h6,
    SEC_RELOAD = 3'h7
  } sec_cmd_t;
endpackage : sec_pkg

// File: testbench/sec_ctrl_sva.sv
// port assertions of the serial eeprom controller
`timescale 1ns/10ps
module sec_ctrl_sva (
  // clock and reset
  input wire logic        clock,
  input wire logic        rst,
  // bus
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  // pins
  input wire logic        serial_clock_pin_o,
  input wire logic        serial_clock_pin_oe,
  input wire logic        serial_data_pin_o,
  input wire logic        serial_data_pin_oe,
  input wire logic        eeprom_select_o
);
  logic       sel_q, clk_q;
  logic [4:0] rises_q;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // count clock rises per select window
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sel_q <= 1'b0;
      clk_q <= 1'b0;
      rises_q <= 5'h00;
    end else begin
      sel_q <= eeprom_select_o;
      clk_q <= serial_clock_pin_o;
      if (eeprom_select_o && !sel_q) rises_q <= 5'h00;
      else if (eeprom_select_o && serial_clock_pin_o && !clk_q) rises_q <= rises_q + 5'h01;
    end
  end
  property p_ack_next; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_pulse; ack_o |=> !ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_rd_hold; $changed(dat_o) |-> ack_o; endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_clk_oe; serial_clock_pin_oe; endproperty
  a_clk_oe: assert property (p_clk_oe) else $error("clock pin not driven");
  property p_frame_low; $rose(eeprom_select_o) |-> !serial_clock_pin_o [*8]; endproperty
  a_frame_low: assert property (p_frame_low) else $error("clock high at select");
  property p_start_bit;
    eeprom_select_o && serial_clock_pin_o && !clk_q && rises_q == 5'h00
      |-> serial_data_pin_oe && serial_data_pin_o;
  endproperty
  a_start_bit: assert property (p_start_bit) else $error("no start bit");
  property p_clk_count;
    !eeprom_select_o && sel_q && rises_q != 5'h00 |-> rises_q == 5'h0A || rises_q == 5'h12;
  endproperty
  a_clk_count: assert property (p_clk_count) else $error("bad clock count");
  property p_dat_stable;
    eeprom_select_o && serial_clock_pin_o && clk_q && serial_data_pin_oe
      |-> $stable(serial_data_pin_o);
  endproperty
  a_dat_stable: assert property (p_dat_stable) else $error("data moved, clock high");
endmodule : sec_ctrl_sva
bind sec_ctrl sec_ctrl_sva u_sva (.clock(clock), .rst(rst), .cyc_i(cyc_i), .stb_i(stb_i),
  .dat_o(dat_o), .ack_o(ack_o), .serial_clock_pin_o(serial_clock_pin_o),
  .serial_clock_pin_oe(serial_clock_pin_oe), .serial_data_pin_o(serial_data_pin_o),
  .serial_data_pin_oe(serial_data_pin_oe), .eeprom_select_o(eeprom_select_o));

// File: testbench/sec_eeprom_model.sv
// behavioural three-wire serial eeprom of 128 bytes
`timescale 1ns/10ps
module sec_eeprom_model (
  // pins of the part
  input wire logic sclk,
  input wire logic cs,
  input wire logic din,
  output logic     dq
);
  logic [7:0]  mem [128];
  logic [17:0] sh;
  logic [31:0] last_n;
  logic [7:0]  rb;
  logic        unl, drv, bq, pend, ok, rdm;
  int          n;
  // powers up locked with a blank array
  initial begin
    {unl, drv, bq, pend} = 4'h0;
    for (int i = 0; i < 128; i++) mem[i] = 8'hFF;
  end
  // released line shows the inverse of its last level
  assign dq = drv ? bq : ~bq;
  // poll: low while busy, high when done; refused ops stay low
  always @(posedge cs) begin
    n = 0;
    rdm = 1'b0;
    drv = pend;
    if (pend) bq = 1'b0;
    if (pend && ok) bq <= #3000 1'b1;
    pend = 1'b0;
  end
  // frame shifts in on rising edges
  always @(posedge sclk) if (cs) begin
    sh = {sh[16:0], din};
    n++;
    if (n == 10) rdm = sh[8:7] == 2'h2;
    if (n == 10) rb = mem[sh[6:0]];
  end
  // read byte leaves msb first on falling edges
  always @(negedge sclk) if (cs && rdm && n >= 10 && n < 18) begin
    drv = 1'b1;
    bq = rb[17 - n];
  end
  // commands act when select drops
  always @(negedge cs) begin
    drv = 1'b0;
    if (n != 0) last_n = 32'(n);
    ok = unl;
    pend = 1'b0;
    if (n == 10 && sh[8:7] == 2'h0) begin
      if (sh[6:5] == 2'h3) unl = 1'b1;
      if (sh[6:5] == 2'h0) unl = 1'b0;
      pend = sh[6:5] == 2'h2;
      if (pend && ok) for (int i = 0; i < 128; i++) mem[i] = 8'hFF;
    end
    if (n == 10 && sh[8:7] == 2'h3) begin
      pend = 1'b1;
      if (ok) mem[sh[6:0]] = 8'hFF;
    end
    if (n == 18 && sh[16:15] == 2'h1) begin
      pend = 1'b1;
      if (ok) mem[sh[14:8]] = sh[7:0];
    end
    if (n == 18 && sh[16:13] == 4'h1) begin
      pend = 1'b1;
      if (ok) for (int i = 0; i < 128; i++) mem[i] = sh[7:0];
    end
  end
endmodule : sec_eeprom_model

// File: testbench/serial_eeprom_controller_tb_top.sv
// self-checking bench of the serial eeprom controller
`timescale 1ns/10ps
module serial_eeprom_controller_tb_top;
  logic        clock, rst, soft_reset, cyc, stb, we, mon_c, mon_d, m_dq, pin_i;
  logic        ack, sck, sck_oe, sdo, sdo_oe, cs, bw;
  logic [7:0]  adr, d;
  logic [6:0]  loc;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, r, lf;
  logic [47:0] mac, sta;
  int          n_errors, checks;
  // controller wins the line while driving
  assign pin_i = sdo_oe ? sdo : m_dq;
  sec_ctrl #(.TIMEOUT_CYC(2000)) dut (.clock(clock), .rst(rst), .soft_reset(soft_reset),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .dat_i(wdat), .sel_i(sel),
    .dat_o(rdat), .ack_o(ack), .serial_clock_pin_o(sck), .serial_clock_pin_oe(sck_oe),
    .serial_data_pin_i(pin_i), .serial_data_pin_o(sdo), .serial_data_pin_oe(sdo_oe),
    .eeprom_select_o(cs), .mii_mon_clk(mon_c), .mii_mon_data(mon_d),
    .station_address(sta), .bus_width_32(bw));
  sec_eeprom_model m (.sclk(sck), .cs(cs), .din(sdo), .dq(m_dq));
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt
  // long frames carry a data byte
  function automatic logic [47:0] flen(input logic [2:0] c);
    return (c == 3'h0 || c == 3'h3 || c == 3'h4) ? 48'h12 : 48'h0A;
  endfunction : flen
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up
  // one classic cycle, read data into r
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
    int i = 0;
    {cyc, stb} <= 2'h3;
    we <= w;
    adr <= a;
    wdat <= v;
    do begin
      @(posedge clock);
      i++;
    end while (ack !== 1'b1 && i < 60);
    if (i >= 60) n_errors++;
    if (i >= 60) wrap_up();
    r = rdat;
    {cyc, stb} <= 2'h0;
    @(posedge clock);
  endtask : wb
  // polls until busy clears
  task automatic idle;
    int i = 0;
    do begin
      wb(1'b0, sec_pkg::OFS_CMD, 32'h0);
      i++;
    end while (r[31] !== 1'b0 && i < 3000);
    if (i >= 3000) n_errors++;
    if (i >= 3000) wrap_up();
  endtask : idle
  task automatic cmd(input logic [2:0] c, input logic [6:0] l);
    wb(1'b1, sec_pkg::OFS_CMD, {1'b1, c, 21'h0, l});
    idle();
    if (c != 3'h7) chk(48'(m.last_n), flen(c));
  endtask : cmd
  task automatic rdloc(input logic [6:0] l);
    cmd(sec_pkg::SEC_READ, l);
    wb(1'b0, sec_pkg::OFS_DATA, 32'h0);
  endtask : rdloc
  initial begin
    {rst, soft_reset, cyc, stb, we, mon_c, mon_d} = 7'h40;
    adr = 8'h00;
    wdat = 32'h0;
    sel = 4'hF;
    n_errors = 0;
    checks = 0;
    lf = 32'h6C21;
    @(posedge clock);
    m.mem[0] = sec_pkg::SIGNATURE;
    for (int i = 1; i < 7; i++) begin
      lf = nxt(lf);
      m.mem[i] = lf[7:0];
      mac[8*(i-1) +: 8] = lf[7:0];
    end
    repeat (11) @(posedge clock);
    rst <= 1'b0;
    idle();
    chk(48'(r[8]), 48'h1);
    chk(sta, mac);
    wb(1'b0, sec_pkg::OFS_ADDR_L, 32'h0);
    chk(48'(r), 48'(mac[31:0]));
    wb(1'b0, sec_pkg::OFS_ADDR_H, 32'h0);
    chk(48'(r), 48'(mac[47:32]));
    wb(1'b0, sec_pkg::OFS_HWCFG, 32'h0);
    chk(48'(r), 48'h4);
    chk(48'(bw), 48'h1);
    wb(1'b0, 8'h3C, 32'h0);
    chk(48'(r), 48'h0);
    // locked part: a write is ignored and times out
    wb(1'b1, sec_pkg::OFS_DATA, 32'h5A);
    cmd(sec_pkg::SEC_WRITE, 7'h7F);
    chk(48'(r[9]), 48'h1);
    chk(48'(m.mem[127]), 48'hFF);
    wb(1'b1, sec_pkg::OFS_CMD, 32'h200);
    wb(1'b0, sec_pkg::OFS_CMD, 32'h0);
    chk(48'(r[9]), 48'h0);
    cmd(sec_pkg::SEC_UNLOCK, 7'h00);
    for (int k = 0; k < 4; k++) begin
      lf = nxt(lf);
      loc = (k == 0) ? 7'h7F : lf[14:8] | 7'h08;
      d = (k == 0) ? 8'h00 : lf[7:0];
      wb(1'b1, sec_pkg::OFS_DATA, 32'(d));
      cmd(sec_pkg::SEC_WRITE, loc);
      chk(48'(m.mem[loc]), 48'(d));
      rdloc(loc);
      chk(48'(r), 48'(d));
    end
    cmd(sec_pkg::SEC_ERASE, loc);
    rdloc(loc);
    chk(48'(r), 48'hFF);
    wb(1'b1, sec_pkg::OFS_DATA, 32'(d));
    cmd(sec_pkg::SEC_FILL, 7'h00);
    rdloc(7'h33);
    chk(48'(r), 48'(d));
    cmd(sec_pkg::SEC_BULK, 7'h00);
    rdloc(7'h33);
    chk(48'(r), 48'hFF);
    // reload without signature fails, address kept
    cmd(sec_pkg::SEC_RELOAD, 7'h00);
    chk(48'(r[8]), 48'h0);
    chk(sta, mac);
    wb(1'b1, sec_pkg::OFS_DATA, 32'(sec_pkg::SIGNATURE));
    cmd(sec_pkg::SEC_WRITE, 7'h00);
    cmd(sec_pkg::SEC_RELOAD, 7'h00);
    chk(48'(r[8]), 48'h1);
    chk(sta, 48'hFFFF_FFFF_FFFF);
    cmd(sec_pkg::SEC_LOCK, 7'h00);
    cmd(sec_pkg::SEC_WRITE, 7'h10);
    chk(48'(r[9]), 48'h1);
    chk(48'(m.mem[16]), 48'hFF);
    wb(1'b1, sec_pkg::OFS_CMD, 32'h200);
    // disabled interface: outputs, then monitors
    wb(1'b1, sec_pkg::OFS_PINCFG, 32'hD);
    repeat (2) @(posedge clock);
    chk(48'({sck, sdo, cs}), 48'h6);
    mon_c <= 1'b1;
    wb(1'b1, sec_pkg::OFS_PINCFG, 32'h3);
    repeat (2) @(posedge clock);
    chk(48'({sck, sdo}), 48'h2);
    wb(1'b1, sec_pkg::OFS_PINCFG, 32'h0);
    soft_reset <= 1'b1;
    @(posedge clock);
    soft_reset <= 1'b0;
    @(posedge clock);
    idle();
    chk(48'(r[8]), 48'h1);
    wrap_up();
  end
endmodule : serial_eeprom_controller_tb_top
